// >>> design/eies_pkg.sv
// Constants, field layouts and bus carrier for the external request enable and sense block.
// Assumes one 40 MHz clock, a synchronous active-low reset and a simple strobe register port.
package eies_pkg;

	localparam int EIES_PINS  = 12;
	localparam int EIES_SEL_W = 2 * EIES_PINS;

	// Register offsets
	localparam logic [7:0] EIES_OFS_ENABLE     = 8'h00;
	localparam logic [7:0] EIES_OFS_SENSE_HIGH = 8'h02;
	localparam logic [7:0] EIES_OFS_SENSE_LOW  = 8'h04;
	localparam logic [7:0] EIES_OFS_STATUS     = 8'h06;
	localparam logic [7:0] EIES_OFS_CLEAR      = 8'h08;

	// Reset values
	localparam logic [11:0] EIES_ENABLE_RESET     = 12'h000;
	localparam logic [7:0]  EIES_SENSE_HIGH_RESET = 8'h00;
	localparam logic [15:0] EIES_SENSE_LOW_RESET  = 16'h0000;
	localparam logic [11:0] EIES_STATUS_RESET     = 12'h000;
	localparam logic [15:0] EIES_RDATA_IDLE       = 16'h0000;

	// Reserved fill above narrow registers
	localparam logic [3:0] EIES_ENABLE_RSVD     = 4'h0;
	localparam logic [7:0] EIES_SENSE_HIGH_RSVD = 8'h00;

	// Synchroniser level while in reset: request pins idle high
	localparam logic EIES_PIN_IDLE = 1'b1;

	// Sense selector codes, rise bit above fall bit
	localparam logic [1:0] EIES_SENSE_LEVEL = 2'h0;
	localparam logic [1:0] EIES_SENSE_FALL  = 2'h1;
	localparam logic [1:0] EIES_SENSE_RISE  = 2'h2;
	localparam logic [1:0] EIES_SENSE_BOTH  = 2'h3;

	// Settling count of the pin pipeline after reset
	localparam logic [1:0] EIES_WARM_DONE = 2'h3;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} eies_bus_req_t;

	// Two-bit selector of one pin out of the joined sense vector
	function automatic logic [1:0] eies_sel(input logic [EIES_SEL_W-1:0] sense, input int idx);
		return sense[2*idx +: 2];
	endfunction : eies_sel

endpackage : eies_pkg

// >>> design/eies_pin_sense.sv
// Pin synchroniser and per-pin condition detector.
// Assumes asynchronous active-low request pins and selectors from the register file.
`timescale 1ns/1ps
module eies_pin_sense
	import eies_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_n,
	// Pins and selection
	input  wire logic [EIES_PINS-1:0]  i_pin_n,
	input  wire logic [EIES_SEL_W-1:0] i_sense,
	// Detected conditions
	output logic      [EIES_PINS-1:0]  o_event
);

	logic [EIES_PINS-1:0] meta;
	logic [EIES_PINS-1:0] level;
	logic [EIES_PINS-1:0] prev;
	logic [EIES_PINS-1:0] sel_level;
	logic [EIES_PINS-1:0] sel_fall;
	logic [EIES_PINS-1:0] sel_rise;
	logic [EIES_PINS-1:0] sel_both;
	logic [1:0]           warm;

	// Two-stage synchroniser, then one stage of history
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			meta  <= {EIES_PINS{EIES_PIN_IDLE}};
			level <= {EIES_PINS{EIES_PIN_IDLE}};
			prev  <= {EIES_PINS{EIES_PIN_IDLE}};
		end else begin
			meta  <= i_pin_n;
			level <= meta;
			prev  <= level;
		end
	end

	// Condition per pin
	always_comb begin
		for (int i = 0; i < EIES_PINS; i++) begin
			sel_level[i] = (eies_sel(i_sense, i) == EIES_SENSE_LEVEL);
			sel_fall[i]  = (eies_sel(i_sense, i) == EIES_SENSE_FALL);
			sel_rise[i]  = (eies_sel(i_sense, i) == EIES_SENSE_RISE);
			sel_both[i]  = (eies_sel(i_sense, i) == EIES_SENSE_BOTH);
			unique case (eies_sel(i_sense, i))
				EIES_SENSE_LEVEL: o_event[i] = ~level[i];
				EIES_SENSE_FALL:  o_event[i] = prev[i] & ~level[i];
				EIES_SENSE_RISE:  o_event[i] = ~prev[i] & level[i];
				EIES_SENSE_BOTH:  o_event[i] = prev[i] ^ level[i];
			endcase
		end
	end

	// Cycles since reset release, for history checks
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			warm <= 2'h0;
		end else if (warm != EIES_WARM_DONE) begin
			warm <= warm + 2'h1;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_low_level_sense: assert property (
		(warm == EIES_WARM_DONE) |-> ((~$past(i_pin_n, 2) & sel_level & ~o_event) == '0))
		else $error("Low pin in level mode gave no request");
	a_falling_edge_only: assert property (
		(warm == EIES_WARM_DONE) |->
		(($past(i_pin_n, 3) & ~$past(i_pin_n, 2) & sel_fall) == (o_event & sel_fall)))
		else $error("Falling edge mode request mismatch");
	a_rising_edge_only: assert property (
		(warm == EIES_WARM_DONE) |->
		((~$past(i_pin_n, 3) & $past(i_pin_n, 2) & sel_rise) == (o_event & sel_rise)))
		else $error("Rising edge mode request mismatch");
	a_both_edges_sense: assert property (
		(warm == EIES_WARM_DONE) |->
		((($past(i_pin_n, 3) ^ $past(i_pin_n, 2)) & sel_both) == (o_event & sel_both)))
		else $error("Both edge mode request mismatch");

endmodule : eies_pin_sense

// >>> design/eies_ctrl.sv
// Enable, sense selection and request flags for twelve external request pins.
// Assumes a strobe register port on i_clock and pins driven asynchronously from the board.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module eies_ctrl
	import eies_pkg::*;
(
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rst_n,
	// Register port
	input  wire eies_bus_req_t        i_bus,
	output logic      [15:0]          o_rdata,
	// External request pins, active low
	input  wire logic [EIES_PINS-1:0] i_request_pin_n,
	// Towards priority and exception logic
	output logic      [EIES_PINS-1:0] o_pin_request,
	output logic                      o_irq
);

	logic [EIES_PINS-1:0]  pin_request_enable;
	logic [7:0]            pin_sense_select_high;
	logic [15:0]           pin_sense_select_low;
	logic [EIES_PINS-1:0]  pin_request_status;
	logic [EIES_SEL_W-1:0] sense_all;
	logic [EIES_SEL_W-1:0] next_sense_all;
	logic [EIES_PINS-1:0]  pin_event;
	logic [EIES_PINS-1:0]  spurious;
	logic [EIES_PINS-1:0]  clear_mask;
	logic [EIES_PINS-1:0]  forward;
	logic [15:0]           wdata;
	logic                  wr_enable;
	logic                  wr_high;
	logic                  wr_low;
	logic                  wr_clear;
	logic                  rd_enable;
	logic                  rd_high;
	logic                  rd_status;

	// Address decode
	assign wdata     = i_bus.wdata;
	assign wr_enable = i_bus.wr && (i_bus.addr == EIES_OFS_ENABLE);
	assign wr_high   = i_bus.wr && (i_bus.addr == EIES_OFS_SENSE_HIGH);
	assign wr_low    = i_bus.wr && (i_bus.addr == EIES_OFS_SENSE_LOW);
	assign wr_clear  = i_bus.wr && (i_bus.addr == EIES_OFS_CLEAR);
	assign rd_enable = i_bus.rd && (i_bus.addr == EIES_OFS_ENABLE);
	assign rd_high   = i_bus.rd && (i_bus.addr == EIES_OFS_SENSE_HIGH);
	assign rd_status = i_bus.rd && (i_bus.addr == EIES_OFS_STATUS);

	// Pins 11-8 from the high register, pins 7-0 from the low register
	assign sense_all = {pin_sense_select_high, pin_sense_select_low};

	eies_pin_sense u_pin_sense (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_pin_n (i_request_pin_n),
		.i_sense (sense_all),
		.o_event (pin_event)
	);

	// Enable register, one bit per pin, upper bits dropped
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pin_request_enable <= EIES_ENABLE_RESET;
		end else if (wr_enable) begin
			pin_request_enable <= wdata[EIES_PINS-1:0];
		end
	end

	// Sense selector registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pin_sense_select_high <= EIES_SENSE_HIGH_RESET;
			pin_sense_select_low  <= EIES_SENSE_LOW_RESET;
		end else begin
			if (wr_high) begin
				pin_sense_select_high <= wdata[7:0];
			end
			if (wr_low) begin
				pin_sense_select_low <= wdata;
			end
		end
	end

	// Selector rewrite sets the flag of every pin whose selection changes
	always_comb begin
		next_sense_all = sense_all;
		if (wr_high) begin
			next_sense_all[EIES_SEL_W-1:16] = wdata[7:0];
		end
		if (wr_low) begin
			next_sense_all[15:0] = wdata;
		end
		for (int i = 0; i < EIES_PINS; i++) begin
			spurious[i] = (eies_sel(next_sense_all, i) != eies_sel(sense_all, i));
		end
	end

	assign clear_mask = wr_clear ? wdata[EIES_PINS-1:0] : '0;

	// Request flags: a set in the cycle of its clear wins
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pin_request_status <= EIES_STATUS_RESET;
		end else begin
			pin_request_status <= (pin_request_status & ~clear_mask) | pin_event | spurious;
		end
	end

	// Forwarding only where flag and enable meet
	assign forward = pin_request_status & pin_request_enable;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_pin_request <= '0;
			o_irq         <= 1'b0;
		end else begin
			o_pin_request <= forward;
			o_irq         <= |forward;
		end
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_rdata <= EIES_RDATA_IDLE;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				EIES_OFS_ENABLE:     o_rdata <= {EIES_ENABLE_RSVD, pin_request_enable};
				EIES_OFS_SENSE_HIGH: o_rdata <= {EIES_SENSE_HIGH_RSVD, pin_sense_select_high};
				EIES_OFS_SENSE_LOW:  o_rdata <= pin_sense_select_low;
				EIES_OFS_STATUS:     o_rdata <= {EIES_ENABLE_RSVD, pin_request_status};
				default:             o_rdata <= EIES_RDATA_IDLE;
			endcase
		end else begin
			o_rdata <= EIES_RDATA_IDLE;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_enable_gates_request: assert property (
		$past(i_rst_n) |-> ((o_pin_request & ~$past(pin_request_enable)) == '0))
		else $error("Request forwarded from a disabled pin");
	a_enable_bit_map: assert property (
		wr_enable |=> (pin_request_enable == $past(wdata[EIES_PINS-1:0])))
		else $error("Enable bits not mapped to pins");
	a_enable_rsvd_zero: assert property (
		rd_enable |=> (o_rdata[15:12] == 4'h0) && (o_rdata[11:0] == pin_request_enable))
		else $error("Enable register readback wrong");
	a_high_rsvd_zero: assert property (
		rd_high |=> (o_rdata[15:8] == 8'h00))
		else $error("Sense high reserved bits not zero");
	a_sense_high_map: assert property (
		wr_high |=> (eies_sel(sense_all, 11) == $past(wdata[7:6]))
		&& (eies_sel(sense_all, 8) == $past(wdata[1:0])))
		else $error("Sense high pin mapping wrong");
	a_spurious_flag_set: assert property (
		(wr_high || wr_low) && (spurious != '0) |=>
		((pin_request_status & $past(spurious)) == $past(spurious)))
		else $error("Selector rewrite did not set flag");
	a_irq_follows_flags: assert property (
		$past(i_rst_n) |-> (o_irq == ($past(forward) != '0))
		&& (o_pin_request == $past(forward)))
		else $error("Interrupt output does not follow flags and enables");
	a_set_beats_clear: assert property (
		$past(i_rst_n) |-> ((pin_request_status & $past(pin_event)) == $past(pin_event)))
		else $error("Detected request lost");
	a_status_readback: assert property (
		rd_status |=> (o_rdata == {4'h0, $past(pin_request_status)}))
		else $error("Status readback wrong");
	a_reset_values_zero: assert property (
		!$past(i_rst_n) |-> (pin_request_enable == '0) && (sense_all == '0) && !o_irq)
		else $error("Registers not zero after reset");

	c_irq_raised: cover property (!o_irq ##1 o_irq);
	c_spurious_set: cover property ((wr_high || wr_low) && (spurious != '0));
	c_clear_while_pending: cover property (wr_clear && ((clear_mask & pin_event) != '0));

endmodule : eies_ctrl

// >>> test/eies_pin_model.sv
// Model of the board devices that pull the twelve request pins low.
// Assumes pull-ups hold released pins high; the bench commands the levels.
`timescale 1ns/1ps
module eies_pin_model
	import eies_pkg::*;
(
	// Clock
	input  wire logic                 i_clock,
	// Commanded levels and pace
	input  wire logic [EIES_PINS-1:0] i_level_n,
	input  wire logic                 i_slow,
	// Request pins
	output logic      [EIES_PINS-1:0] o_pin_n
);
	logic [1:0] wait_cnt;

	initial begin
		o_pin_n  = {EIES_PINS{1'b1}};
		wait_cnt = 2'h0;
	end

	// Pins move between clock edges; a slow device lags three cycles
	always @(negedge i_clock) begin
		if (i_level_n === o_pin_n || (i_slow && wait_cnt != 2'h3)) begin
			wait_cnt <= (i_level_n === o_pin_n) ? 2'h0 : wait_cnt + 2'h1;
		end else begin
			o_pin_n  <= i_level_n;
			wait_cnt <= 2'h0;
		end
	end
endmodule : eies_pin_model

// >>> test/external_irq_enable_sense_test.sv
// Self-checking bench for the external request enable and sense block.
// Assumes the pin model on the request pins and the strobe register port.
`timescale 1ns/1ps
module external_irq_enable_sense_test import eies_pkg::*;;
	logic                 i_clock;
	logic                 i_rst_n;
	eies_bus_req_t        bus;
	logic [15:0]          o_rdata;
	logic [EIES_PINS-1:0] o_pin_request;
	logic                 o_irq;
	logic [EIES_PINS-1:0] pin_n;
	logic [EIES_PINS-1:0] level_n;
	logic                 slow;
	logic                 rd_d;
	logic                 peek;
	logic [15:0]          q_rd[$];
	logic [12:0]          q_irq[$];
	int                   bad_count;
	int                   checks_done;
	int                   p;
	logic [15:0]          v;

	eies_ctrl dut (
		.i_clock         (i_clock),
		.i_rst_n         (i_rst_n),
		.i_bus           (bus),
		.o_rdata         (o_rdata),
		.i_request_pin_n (pin_n),
		.o_pin_request   (o_pin_request),
		.o_irq           (o_irq)
	);

	eies_pin_model board (
		.i_clock   (i_clock),
		.i_level_n (level_n),
		.i_slow    (slow),
		.o_pin_n   (pin_n)
	);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	task automatic complete_run;
		$display("Mismatches %0d, comparisons %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	task automatic note(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : note

	task automatic cmp_rdata(input logic [15:0] got);
		note("rdata", q_rd.pop_front(), got);
	endtask : cmp_rdata

	task automatic cmp_irq(input logic [12:0] got);
		note("irq_request", {3'h0, q_irq.pop_front()}, {3'h0, got});
	endtask : cmp_irq

	task automatic op(input logic [7:0] a, input logic [15:0] d, input logic w, input logic r);
		@(posedge i_clock);
		bus <= '{a, d, w, r};
		@(posedge i_clock);
		bus <= '{8'h00, 16'h0000, 1'b0, 1'b0};
	endtask : op

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		op(a, d, 1'b1, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		q_rd.push_back(e);
		op(a, 16'h0000, 1'b0, 1'b1);
	endtask : rd

	task automatic irq_is(input logic e_irq, input logic [11:0] e_req);
		q_irq.push_back({e_irq, e_req});
		@(posedge i_clock);
		peek <= 1'b1;
		@(posedge i_clock);
		peek <= 1'b0;
	endtask : irq_is

	// Results are taken from the outputs one cycle after each strobe
	always @(posedge i_clock) begin
		if (rd_d === 1'b1) cmp_rdata(o_rdata);
		if (peek === 1'b1) cmp_irq({o_irq, o_pin_request});
		rd_d = bus.rd;
	end

	initial begin
		repeat (3000) @(posedge i_clock);
		bad_count++;
		complete_run();
	end

	initial begin
		i_rst_n     = 1'b0;
		bus         = '{8'h00, 16'h0000, 1'b0, 1'b0};
		level_n     = 12'hfff;
		slow        = 1'b0;
		rd_d        = 1'b0;
		peek        = 1'b0;
		bad_count   = 0;
		checks_done = 0;
		v = 16'($urandom(32'heb1e));
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(EIES_OFS_ENABLE, 16'h0000);
		rd(EIES_OFS_SENSE_HIGH, 16'h0000);
		rd(EIES_OFS_SENSE_LOW, 16'h0000);
		rd(EIES_OFS_STATUS, 16'h0000);
		// Register layout and the unmapped place
		v = 16'($urandom());
		wr(EIES_OFS_SENSE_HIGH, {8'h00, v[7:0]});
		rd(EIES_OFS_SENSE_HIGH, {8'h00, v[7:0]});
		wr(EIES_OFS_SENSE_LOW, v);
		rd(EIES_OFS_SENSE_LOW, v);
		wr(EIES_OFS_CLEAR, 16'h0fff);
		wr(EIES_OFS_ENABLE, {4'h0, v[11:0]});
		rd(EIES_OFS_ENABLE, {4'h0, v[11:0]});
		wr(8'h0a, 16'hffff);
		rd(8'h0a, 16'h0000);
		wr(EIES_OFS_STATUS, 16'h0fff);
		rd(EIES_OFS_STATUS, 16'h0000);
		// Every sense code, all pins low then high, one random pin enabled
		for (int m = 0; m < 4; m++) begin
			p = $urandom_range(11, 0);
			slow <= m[0];
			wr(EIES_OFS_ENABLE, 16'h0000);
			wr(EIES_OFS_SENSE_HIGH, {8'h00, {4{m[1:0]}}});
			wr(EIES_OFS_SENSE_LOW, {8{m[1:0]}});
			repeat (2) @(posedge i_clock);
			if (m > 0) rd(EIES_OFS_STATUS, 16'h0fff);
			irq_is(1'b0, 12'h000);
			wr(EIES_OFS_CLEAR, 16'h0fff);
			wr(EIES_OFS_ENABLE, 16'h0001 << p);
			rd(EIES_OFS_STATUS, 16'h0000);
			level_n <= 12'h000;
			repeat (10) @(posedge i_clock);
			rd(EIES_OFS_STATUS, (m != 2) ? 16'h0fff : 16'h0000);
			irq_is(m != 2, (m != 2) ? 12'h001 << p : 12'h000);
			wr(EIES_OFS_CLEAR, 16'h0fff);
			level_n <= 12'hfff;
			repeat (10) @(posedge i_clock);
			rd(EIES_OFS_STATUS, (m != 1) ? 16'h0fff : 16'h0000);
			irq_is(m != 1, (m != 1) ? 12'h001 << p : 12'h000);
		end
		// Reset again with flags and an enable set
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(EIES_OFS_ENABLE, 16'h0000);
		rd(EIES_OFS_SENSE_LOW, 16'h0000);
		rd(EIES_OFS_STATUS, 16'h0000);
		irq_is(1'b0, 12'h000);
		repeat (3) @(posedge i_clock);
		complete_run();
	end
endmodule : external_irq_enable_sense_test
